// >>> bct_pkg.sv
// Package with opcodes, flag positions and cycle counts for the branch and bit-test unit.
package bct_pkg;
  localparam logic [7:0] OP_BRANCH_HALF_CARRY_CLEAR      = 8'h28;
  localparam logic [7:0] OP_BRANCH_HALF_CARRY_SET        = 8'h29;
  localparam logic [7:0] OP_BRANCH_UNSIGNED_GREATER      = 8'h22;
  localparam logic [7:0] OP_BRANCH_UNSIGNED_GREATER_EQUAL = 8'h24;
  localparam logic [7:0] OP_BRANCH_INT_PIN_HIGH          = 8'h2f;
  localparam logic [7:0] OP_BRANCH_INT_PIN_LOW           = 8'h2e;
  localparam logic [7:0] OP_BRANCH_SIGNED_LESS_EQUAL     = 8'h93;
  localparam logic [7:0] OP_BRANCH_UNSIGNED_LESS         = 8'h25;
  localparam logic [7:0] OP_BRANCH_UNSIGNED_LESS_EQUAL   = 8'h23;
  localparam logic [7:0] OP_BIT_IMM                      = 8'ha5;
  localparam logic [7:0] OP_BIT_DIR                      = 8'hb5;
  localparam logic [7:0] OP_BIT_EXT                      = 8'hc5;
  localparam logic [7:0] OP_BIT_IX2                      = 8'hd5;
  localparam logic [7:0] OP_BIT_IX1                      = 8'he5;
  localparam logic [7:0] OP_BIT_IX                       = 8'hf5;
  localparam logic [7:0] OP_PREFIX_STACK                 = 8'h9e;
  localparam logic [7:0] OP_BIT_SP2                      = 8'hd5;
  localparam logic [7:0] OP_BIT_SP1                      = 8'he5;
  // Flag positions inside the condition code register.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I = 3;
  localparam int FLAG_H = 4;
  localparam int FLAG_V = 7;
  localparam logic [7:0]  CCR_RESET       = 8'h60;
  localparam logic [15:0] BRANCH_PC_STEP  = 16'h0002;
  localparam logic [2:0]  CYC_BRANCH      = 3'h3;
  localparam logic [2:0]  CYC_BIT_IMM     = 3'h2;
  localparam logic [2:0]  CYC_BIT_DIR     = 3'h3;
  localparam logic [2:0]  CYC_BIT_EXT     = 3'h4;
  localparam logic [2:0]  CYC_BIT_IX2     = 3'h4;
  localparam logic [2:0]  CYC_BIT_IX1     = 3'h3;
  localparam logic [2:0]  CYC_BIT_IX      = 3'h3;
  localparam logic [2:0]  CYC_BIT_SP2     = 3'h5;
  localparam logic [2:0]  CYC_BIT_SP1     = 3'h4;
endpackage

// >>> bct_cond.sv
// Branch condition evaluator for the relative branch group.
`timescale 1ns/100ps
module bct_cond (
  input  wire logic [7:0] i_opcode,
  input  wire logic [7:0] i_ccr,
  input  wire logic       i_int_pin,
  output logic            o_known,
  output logic            o_take
);
  import bct_pkg::*;

  wire c = i_ccr[FLAG_C];
  wire z = i_ccr[FLAG_Z];
  wire n = i_ccr[FLAG_N];
  wire h = i_ccr[FLAG_H];
  wire v = i_ccr[FLAG_V];

  always_comb begin
    o_known = 1'b1;
    o_take  = 1'b0;
    case (i_opcode)
      OP_BRANCH_HALF_CARRY_CLEAR:       o_take = ~h;
      OP_BRANCH_HALF_CARRY_SET:         o_take = h;
      OP_BRANCH_UNSIGNED_GREATER:       o_take = ~(c | z);
      OP_BRANCH_UNSIGNED_GREATER_EQUAL: o_take = ~c;
      OP_BRANCH_INT_PIN_HIGH:           o_take = i_int_pin;
      OP_BRANCH_INT_PIN_LOW:            o_take = ~i_int_pin;
      OP_BRANCH_SIGNED_LESS_EQUAL:      o_take = z | (n ^ v);
      OP_BRANCH_UNSIGNED_LESS:          o_take = c;
      OP_BRANCH_UNSIGNED_LESS_EQUAL:    o_take = c | z;
      default:                          o_known = 1'b0;
    endcase
  end
endmodule

// >>> bct_core.sv
// Execute unit for the conditional branches and the bit-test instruction.
`timescale 1ns/100ps
module bct_core (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_start,
  input  wire logic        i_prefix,
  input  wire logic [7:0]  i_opcode,
  input  wire logic [15:0] i_op_addr,
  input  wire logic [7:0]  i_rel,
  input  wire logic [7:0]  i_acc,
  input  wire logic [7:0]  i_operand,
  input  wire logic        i_int_pin,
  input  wire logic        i_ccr_load,
  input  wire logic [7:0]  i_ccr_in,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_illegal,
  output logic             o_pc_load,
  output logic [15:0]      o_pc,
  output logic [7:0]       o_ccr,
  output logic [7:0]       o_acc
);
  import bct_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } state_t;

  function automatic logic [2:0] bit_cycles(input logic pfx, input logic [7:0] op);
    logic [2:0] cyc;
    cyc = 3'h0;
    if (pfx) begin
      case (op)
        OP_BIT_SP2: cyc = CYC_BIT_SP2;
        OP_BIT_SP1: cyc = CYC_BIT_SP1;
        default:    cyc = 3'h0;
      endcase
    end else begin
      case (op)
        OP_BIT_IMM: cyc = CYC_BIT_IMM;
        OP_BIT_DIR: cyc = CYC_BIT_DIR;
        OP_BIT_EXT: cyc = CYC_BIT_EXT;
        OP_BIT_IX2: cyc = CYC_BIT_IX2;
        OP_BIT_IX1: cyc = CYC_BIT_IX1;
        OP_BIT_IX:  cyc = CYC_BIT_IX;
        default:    cyc = 3'h0;
      endcase
    end
    return cyc;
  endfunction

  state_t      state_r;
  logic [2:0]  count_r;
  logic [7:0]  ccr_r;
  logic [15:0] pc_r;
  logic        pc_load_r;
  logic        done_r;
  logic        illegal_r;
  logic [7:0]  acc_r;
  logic        is_bit_r;
  logic [15:0] target_r;
  logic        take_r;
  logic [7:0]  result_r;

  wire         br_known;
  wire         br_take;

  bct_cond u_cond (
    .i_opcode  (i_opcode),
    .i_ccr     (ccr_r),
    .i_int_pin (i_int_pin),
    .o_known   (br_known),
    .o_take    (br_take)
  );

  wire [2:0]  bit_cyc    = bit_cycles(i_prefix, i_opcode);
  wire        is_bit     = (bit_cyc != 3'h0);
  wire        is_branch  = br_known & ~i_prefix;
  wire        accept     = i_start & (state_r == ST_IDLE);
  // Offset is sign extended before the add so backward branches wrap correctly.
  wire [15:0] target     = i_op_addr + BRANCH_PC_STEP + {{8{i_rel[7]}}, i_rel};
  wire [7:0]  and_result = i_acc & i_operand;
  wire        last       = (state_r == ST_RUN) && (count_r == 3'h1);

  // The bit-test flag image; H, I and C pass through untouched.
  wire [7:0]  bit_ccr = {1'b0, ccr_r[6:3], result_r[7], (result_r == 8'h00),
                         ccr_r[FLAG_C]};

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  // Next values are formed here so that each flop block below stays short.
  wire        launch     = accept & (is_bit | is_branch);
  wire        reject     = accept & ~is_bit & ~is_branch;
  wire        finish_br  = last & ~is_bit_r;
  wire        finish_bit = last & is_bit_r;
  wire        idle       = (state_r == ST_IDLE);
  wire        jump       = finish_br & take_r;
  // Software loads are honoured only while idle, so they never meet an execute update.
  wire [7:0]  ccr_nxt    = finish_bit ? bit_ccr
                         : (i_ccr_load & idle) ? i_ccr_in : ccr_r;
  state_t     state_nxt;
  logic [2:0] count_nxt;

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      ST_IDLE: begin
        if (launch) begin
          state_nxt = ST_RUN;
          // A branch costs three cycles taken or not.
          count_nxt = is_bit ? bit_cyc : CYC_BRANCH;
        end
      end
      ST_RUN: begin
        count_nxt = count_r - 3'h1;
        if (last) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        count_nxt = 3'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State and operand capture
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      count_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  // Operands are taken once at the accept edge; later input changes are ignored.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      is_bit_r <= 1'b0;
      target_r <= 16'h0000;
      take_r   <= 1'b0;
      result_r <= 8'h00;
    end else if (launch) begin
      is_bit_r <= is_bit;
      target_r <= target;
      take_r   <= br_take;
      result_r <= and_result;
    end
  end

  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= reject;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pc_load_r <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      pc_load_r <= jump;
      done_r    <= last;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pc_r <= 16'h0000;
    end else if (jump) begin
      pc_r <= target_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ccr_r <= CCR_RESET;
    end else begin
      ccr_r <= ccr_nxt;
    end
  end

  // Accumulator is only mirrored; bit-test never writes it.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      acc_r <= 8'h00;
    end else if (idle) begin
      acc_r <= i_acc;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The one-hot run bit is itself a flop, so busy needs no decode gate.
  assign o_busy    = state_r[1];
  assign o_done    = done_r;
  assign o_illegal = illegal_r;
  assign o_pc_load = pc_load_r;
  assign o_pc      = pc_r;
  assign o_ccr     = ccr_r;
  assign o_acc     = acc_r;
endmodule

// >>> bct_core_asserts.sv
// Checker for the branch and bit-test execute unit.
`timescale 1ns/100ps
module bct_core_chk
  import bct_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_start,
  input wire logic        i_prefix,
  input wire logic [7:0]  i_opcode,
  input wire logic [15:0] i_op_addr,
  input wire logic [7:0]  i_rel,
  input wire logic [7:0]  i_acc,
  input wire logic [7:0]  i_operand,
  input wire logic        i_ccr_load,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic        o_pc_load,
  input wire logic [15:0] o_pc,
  input wire logic [7:0]  o_ccr
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire acc_w = i_start & ~o_busy;
  wire br_w = acc_w & ~i_prefix
    & (i_opcode inside {8'h22, 8'h23, 8'h24, 8'h25, 8'h28, 8'h29, 8'h2e, 8'h2f, 8'h93});
  wire bit_w = acc_w & ~i_prefix & (i_opcode == OP_BIT_IMM);
  wire [15:0] tgt_w = i_op_addr + BRANCH_PC_STEP + {{8{i_rel[7]}}, i_rel};
  br_len_a: assert property (br_w |=> o_busy [*3] ##1 o_done)
    else $error("branch length wrong");
  br_flags_a: assert property (br_w & ~i_ccr_load |=> $stable(o_ccr) [*4])
    else $error("branch changed flags");
  br_target_a: assert property (br_w |-> ##4 (!o_pc_load || o_pc == $past(tgt_w, 4)))
    else $error("branch target wrong");
  hc_clear_a: assert property (br_w & (i_opcode == 8'h28) & ~o_ccr[FLAG_H] |-> ##4 o_pc_load)
    else $error("half-carry-clear branch not taken");
  hc_set_a: assert property (br_w & (i_opcode == 8'h29) & ~o_ccr[FLAG_H] |-> ##4 !o_pc_load)
    else $error("half-carry-set branch taken");
  load_done_a: assert property (o_pc_load |-> o_done)
    else $error("pc load without done");
  bit_len_a: assert property (bit_w |=> o_busy [*2] ##1 o_done)
    else $error("immediate bit-test length wrong");
  sp2_len_a: assert property (acc_w & i_prefix & (i_opcode == OP_BIT_SP2) |=> o_busy [*5] ##1 o_done)
    else $error("stack bit-test length wrong");
  bit_flags_a: assert property (bit_w |-> ##3 (!o_ccr[FLAG_V] && o_ccr[FLAG_N] == $past(i_acc[7] & i_operand[7], 3) && o_ccr[FLAG_Z] == ($past(i_acc & i_operand, 3) == 8'h00)))
    else $error("bit-test flags wrong");
endmodule
bind bct_core bct_core_chk i_chk (.*);

// >>> tb_top.sv
// Self-checking bench for the branch and bit-test execute unit.
`timescale 1ns/100ps
module tb_top;
  logic        i_clk, i_rst, i_start, i_prefix, i_int_pin, i_ccr_load;
  logic [7:0]  i_opcode, i_rel, i_acc, i_operand, i_ccr_in, o_ccr, o_acc;
  logic [15:0] i_op_addr, o_pc;
  logic        o_busy, o_done, o_illegal, o_pc_load;
  int          errors, n_compared;
  // Row: opcode, flags, pin, taken.
  logic [19:0] rows [22] = '{20'h28601, 20'h28700, 20'h29701, 20'h29600, 20'h22601,
    20'h22610, 20'h22620, 20'h24621, 20'h24610, 20'h2f603, 20'h2f600, 20'h2e601,
    20'h2e602, 20'h93600, 20'h93621, 20'h93641, 20'h93e40, 20'h93e01, 20'h25611,
    20'h23600, 20'h23611, 20'h23621};
  // Row: prefix, opcode, cycles.
  logic [15:0] bits [8] = '{16'h0a52, 16'h0b53, 16'h0c54, 16'h0d54, 16'h0e53, 16'h0f53,
    16'h1d55, 16'h1e54};
  bct_core i_dut (.*);
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic ld(input logic [7:0] v);
    i_ccr_load = 1'b1;
    i_ccr_in = v;
    @(negedge i_clk);
    i_ccr_load = 1'b0;
  endtask
  task automatic run(input logic p, input logic [7:0] op, input logic [2:0] n);
    int k;
    i_prefix = p;
    i_opcode = op;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    k = 1;
    while (o_done !== 1'b1 && k < 20) begin
      @(negedge i_clk);
      k++;
    end
    chk(16'(k), 16'(n) + 16'h1);
  endtask
  task automatic finish_test;
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    finish_test();
  end
  initial begin
    logic [7:0] r;
    {i_rst, i_start, i_prefix, i_int_pin, i_ccr_load} = 5'h10;
    {i_opcode, i_rel, i_acc, i_operand, i_ccr_in, i_op_addr} = '0;
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    chk({o_pc, o_ccr, o_acc}, {16'h0000, bct_pkg::CCR_RESET, 8'h00});
    chk({o_busy, o_done, o_illegal, o_pc_load}, 4'h0);
    $display("reset test done");
    i_rel = 8'h7f;
    for (int j = 0; j < 22; j++) begin
      ld(rows[j][11:4]);
      i_int_pin = rows[j][1];
      i_op_addr = 16'h1000 + 16'(j);
      run(1'b0, rows[j][19:12], 3'h3);
      chk(16'(o_pc_load), 16'(rows[j][0]));
      if (rows[j][0]) chk(o_pc, i_op_addr + 16'h0081);
      chk(16'(o_ccr), 16'(rows[j][11:4]));
    end
    $display("branch rows done");
    for (int j = 0; j < 8; j++) begin
      ld(8'hff);
      i_acc = 8'hc3;
      i_operand = 8'h80 >> j;
      run(bits[j][12], bits[j][11:4], bits[j][2:0]);
      r = 8'hc3 & (8'h80 >> j);
      chk(16'(o_ccr), {8'h0, 5'b01111, r[7], r == 8'h00, 1'b1});
      chk(16'(o_acc), 16'h00c3);
    end
    $display("bit-test rows done");
    ld(8'h60);
    i_prefix = 1'b0;
    i_op_addr = 16'h0010;
    i_rel = 8'h80;
    i_opcode = 8'h28;
    i_start = 1'b1;
    @(negedge i_clk);
    i_opcode = 8'ha5;
    repeat (2) @(negedge i_clk);
    i_start = 1'b0;
    @(negedge i_clk);
    chk({o_done, o_pc_load, o_pc}, 18'h3ff92);
    i_opcode = 8'h01;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    chk({o_illegal, o_busy}, 2'h2);
    $display("busy and illegal test done");
    ld(8'h70);
    run(1'b0, 8'h29, 3'h3);
    i_opcode = 8'h24;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    i_rst = 1'b1;
    @(negedge i_clk);
    i_rst = 1'b0;
    chk({o_busy, o_done, o_ccr}, 10'h060);
    run(1'b0, 8'h24, 3'h3);
    chk(16'(o_pc_load), 16'h0001);
    chk(o_pc, 16'hff92);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
